// ---- inc/apec_pkg.sv ----
package apec_pkg;
    localparam logic [31:0] APEC_CTR_BASE    = 32'h0000_00c1;
    localparam logic [31:0] APEC_SEL_BASE    = 32'h0000_0186;
    localparam int          APEC_EVT_LSB     = 0;
    localparam int          APEC_QUAL_LSB    = 8;
    localparam int          APEC_USR_BIT     = 16;
    localparam int          APEC_KRN_BIT     = 17;
    localparam int          APEC_EDGE_BIT    = 18;
    localparam int          APEC_PIN_BIT     = 19;
    localparam int          APEC_INT_BIT     = 20;
    localparam int          APEC_RSV_BIT     = 21;
    localparam int          APEC_EN_BIT      = 22;
    localparam int          APEC_FLIP_BIT    = 23;
    localparam int          APEC_THR_LSB     = 24;
    localparam int          APEC_SIGN_BIT    = 31;
    localparam logic [63:0] APEC_SEL_RST     = 64'h0;
    localparam logic [63:0] APEC_SEL_WMASK   = 64'h0000_0000_ffdf_ffff;
    localparam int          APEC_VER_LSB     = 0;
    localparam int          APEC_NUM_LSB     = 8;
    localparam int          APEC_WID_LSB     = 16;

    typedef struct packed {
        logic        wr;
        logic        rd;
        logic [31:0] addr;
        logic [63:0] data;
    } apec_req_t;

    typedef struct packed {
        logic        valid;
        logic        fault;
        logic [63:0] data;
    } apec_rsp_t;
endpackage : apec_pkg

// ---- hdl/apec_bank.sv ----
`timescale 1ns/1ps
// One bank serves one logical processor; instantiate one per thread.
module apec_bank
    import apec_pkg::*;
#(
    parameter int          NCTR     = 4,
    parameter int          CWID     = 48,
    parameter int          OCCW     = 4,
    parameter logic [7:0]  VERSION  = 8'h01,
    parameter logic [31:0] EVT_MASK = 32'h0000_0000,
    // Nonzero marks later-version fields this bank does not support.
    parameter logic [63:0] UNSUP    = 64'h0000_0000_0008_0000
) (
    input  wire logic                 clk_i,
    input  wire logic                 rst_i,
    input  wire apec_req_t            req_i,
    input  wire logic [1:0]           cpl_i,
    input  wire logic [NCTR*256*OCCW-1:0] occ_i,
    output apec_rsp_t                 rsp_o,
    output logic [31:0]               cap_eax_o,
    output logic [31:0]               cap_ebx_o,
    output logic [NCTR-1:0]           irq_o,
    output logic [NCTR-1:0]           monitor_pins_o
);
    logic [63:0]      sel_r  [NCTR];
    logic [CWID-1:0]  ctr_r  [NCTR];
    logic [NCTR-1:0]  cond_prev_r;
    logic [NCTR-1:0]  ovf_nxt;
    logic [NCTR-1:0]  evt_nxt;
    apec_rsp_t        rsp_nxt;

    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            cap_eax_o <= 32'h0;
            cap_ebx_o <= 32'h0;
        end else begin
            cap_eax_o <= {8'h00, 8'(CWID), 8'(NCTR), VERSION};
            // The count byte and width byte above.
            cap_ebx_o <= ~EVT_MASK;
        end
    end

    genvar g;
    generate
        for (g = 0; g < NCTR; g++) begin : g_ctr
            logic [63:0]     s;
            logic [7:0]      evt;
            logic [7:0]      thr;
            logic [OCCW-1:0] occ;
            logic            lvl_ok;
            logic            pass;
            logic            cond;
            logic [CWID:0]   inc;
            logic [CWID:0]   sum;
            logic            hit_ctr;
            logic            hit_sel;
            assign s   = sel_r[g];
            assign evt = s[APEC_EVT_LSB +: 8];
            assign thr = s[APEC_THR_LSB +: 8];
            // A nonzero qualifier passes the unit's occupancy through; a zero qualifier forces it to zero.
            assign occ = (s[APEC_QUAL_LSB +: 8] != 8'h00)
                ? occ_i[(g*256 + evt)*OCCW +: OCCW] : '0;
            assign lvl_ok = (s[APEC_USR_BIT] && cpl_i != 2'h0)
                         || (s[APEC_KRN_BIT] && cpl_i == 2'h0);
            // Compared at full width so a threshold above the occupancy
            // range can never pass by truncation.
            assign pass = (32'(thr) <= 32'(occ)) ^ s[APEC_FLIP_BIT];
            assign cond = lvl_ok && ((thr == 8'h00) ? (occ != '0) : pass);
            always_comb begin
                inc = '0;
                if (s[APEC_EN_BIT]) begin
                    if (s[APEC_EDGE_BIT])
                        inc = (CWID+1)'(cond && !cond_prev_r[g]);
                    else if (thr != 8'h00)
                        inc = (CWID+1)'(cond);
                    else if (lvl_ok)
                        inc = (CWID+1)'(occ);
                end
            end
            assign sum = {1'b0, ctr_r[g]} + inc;
            assign ovf_nxt[g] = sum[CWID];
            assign evt_nxt[g] = inc != '0;
            assign hit_ctr = req_i.wr && req_i.addr == APEC_CTR_BASE + g;
            assign hit_sel = req_i.wr && req_i.addr == APEC_SEL_BASE + g
                          && (req_i.data & UNSUP) == 64'h0;

            always_ff @(posedge clk_i or posedge rst_i) begin
                if (rst_i) begin
                    sel_r[g] <= APEC_SEL_RST;
                end else if (hit_sel) begin
                    sel_r[g] <= req_i.data & APEC_SEL_WMASK;
                end
            end

            always_ff @(posedge clk_i or posedge rst_i) begin
                if (rst_i) begin
                    ctr_r[g] <= '0;
                end else if (hit_ctr) begin
                    // Writing while enabled loses the cycle's count.
                    ctr_r[g] <= CWID'({{32{req_i.data[APEC_SIGN_BIT]}},
                                       req_i.data[31:0]});
                end else begin
                    ctr_r[g] <= sum[CWID-1:0];
                end
            end

            always_ff @(posedge clk_i or posedge rst_i) begin
                if (rst_i) begin
                    cond_prev_r[g]    <= 1'b0;
                    irq_o[g]          <= 1'b0;
                    monitor_pins_o[g] <= 1'b0;
                end else begin
                    cond_prev_r[g]    <= cond;
                    irq_o[g]          <= ovf_nxt[g] && s[APEC_INT_BIT];
                    monitor_pins_o[g] <= s[APEC_PIN_BIT] ? evt_nxt[g]
                                                         : ovf_nxt[g];
                end
            end
        end
    endgenerate

    always_comb begin
        rsp_nxt = '0;
        rsp_nxt.valid = req_i.wr || req_i.rd;
        for (int i = 0; i < NCTR; i++) begin
            if (req_i.addr == APEC_CTR_BASE + i)
                rsp_nxt.data = 64'(ctr_r[i]);
            if (req_i.addr == APEC_SEL_BASE + i)
                rsp_nxt.data = sel_r[i];
        end
        if (req_i.wr && (req_i.data & UNSUP) != 64'h0
            && req_i.addr >= APEC_SEL_BASE
            && req_i.addr < APEC_SEL_BASE + NCTR)
            rsp_nxt.fault = 1'b1;
        if (!req_i.rd)
            rsp_nxt.data = 64'h0;
    end

    // Private state per instance keeps threads apart.
    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            rsp_o <= '0;
        end else begin
            rsp_o <= rsp_nxt;
        end
    end
endmodule : apec_bank

// ---- verif/apec_bank_assertions.sv ----
`timescale 1ns/1ps
module apec_bank_assertions
    import apec_pkg::*;
#(
    parameter int          NCTR     = 4,
    parameter int          CWID     = 48,
    parameter logic [7:0]  VERSION  = 8'h01,
    parameter logic [31:0] EVT_MASK = 32'h0,
    parameter logic [63:0] UNSUP    = 64'h0
) (
    input  wire logic            clk_i,
    input  wire logic            rst_i,
    input  wire apec_req_t       req_i,
    input  wire apec_rsp_t       rsp_o,
    input  wire logic [31:0]     cap_eax_o,
    input  wire logic [31:0]     cap_ebx_o,
    input  wire logic [NCTR-1:0] irq_o
);
    logic req, sel, bad, hit;
    assign req = req_i.wr | req_i.rd;
    assign sel = (req_i.addr - APEC_SEL_BASE) < 32'(NCTR);
    assign bad = req_i.wr && sel && |(req_i.data & UNSUP);
    assign hit = sel || ((req_i.addr - APEC_CTR_BASE) < 32'(NCTR));
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (rst_i);
    a_rsp_after_req: assert property (req |=> rsp_o.valid)
        else $error("no answer one cycle after a request");
    a_rsp_only_req: assert property (!req |=> !rsp_o.valid)
        else $error("answer without a request");
    a_fault_on_unsup: assert property (bad |=> rsp_o.fault)
        else $error("unsupported field write not refused");
    a_fault_has_cause: assert property (rsp_o.fault |-> $past(bad))
        else $error("fault without an unsupported field write");
    a_write_data_zero: assert property (req_i.wr |=> rsp_o.data == 64'h0)
        else $error("write answer carries data");
    a_unmapped_zero: assert property (req_i.rd && !hit |=> rsp_o.data == 64'h0)
        else $error("unmapped read returned data");
    a_cap_eax_val: assert property (!$past(rst_i) |-> cap_eax_o ==
        {8'h00, 8'(CWID), 8'(NCTR), VERSION}) else $error("bad capability word");
    a_cap_ebx_val: assert property (!$past(rst_i) |-> cap_ebx_o == ~EVT_MASK)
        else $error("bad event support word");
    a_irq_one_pulse: assert property (|irq_o |=> !(|irq_o))
        else $error("interrupt request longer than one cycle");
endmodule : apec_bank_assertions
bind apec_bank apec_bank_assertions #(.NCTR(NCTR), .CWID(CWID),
    .VERSION(VERSION), .EVT_MASK(EVT_MASK), .UNSUP(UNSUP)) u_chk (
    .clk_i(clk_i), .rst_i(rst_i), .req_i(req_i), .rsp_o(rsp_o),
    .cap_eax_o(cap_eax_o), .cap_ebx_o(cap_ebx_o), .irq_o(irq_o));

// ---- verif/tb_top.sv ----
`timescale 1ns/1ps
module tb_top;
    import apec_pkg::*;
    logic          clk_i = 1'b0;
    logic          rst_i = 1'b1;
    apec_req_t     req_i = '0;
    logic [1:0]    cpl_i = 2'h0;
    logic [2047:0] occ_i = '0;
    apec_rsp_t     rsp_o;
    logic [31:0]   eax, ebx;
    logic [1:0]    irq, pin;
    logic [63:0]   got;
    logic          flt, si, sp;
    int            fail_count = 0;
    int            check_count = 0;
    int            cyc = 0;
    // A 40-bit counter keeps sign fill visible while overflow stays reachable.
    apec_bank #(.NCTR(2), .CWID(40), .OCCW(4), .EVT_MASK(32'h0000_0005)) uut (
        .clk_i(clk_i), .rst_i(rst_i), .req_i(req_i), .cpl_i(cpl_i),
        .occ_i(occ_i), .rsp_o(rsp_o), .cap_eax_o(eax), .cap_ebx_o(ebx),
        .irq_o(irq), .monitor_pins_o(pin));
    always #50 clk_i = ~clk_i;
    always @(posedge clk_i) begin
        cyc <= cyc + 1;
        if (cyc == 3000) begin
            fail_count++;
            end_of_test();
        end
    end
    task automatic chk(input string n, input logic [63:0] e, g);
        check_count++;
        if (g !== e) begin
            fail_count++;
            $display("[FAIL] %s expected %h seen %h", n, e, g);
        end
    endtask : chk
    task automatic acc(input logic w, input logic [31:0] a, input logic [63:0] d);
        @(negedge clk_i);
        req_i = '{w, !w, a, d};
        @(negedge clk_i);
        req_i = '0;
        got = rsp_o.data;
        flt = rsp_o.fault;
        chk("valid", 64'h1, {63'h0, rsp_o.valid});
    endtask : acc
    task automatic t_regs();
        acc(1, APEC_SEL_BASE + 1, 64'h1_0023_0101);
        acc(0, APEC_SEL_BASE + 1, 64'h0);
        chk("sel1", 64'h0003_0101, got);
        acc(1, APEC_SEL_BASE + 1, 64'h0008_0000);
        chk("fault", 64'h1, {63'h0, flt});
        acc(0, APEC_SEL_BASE + 1, 64'h0);
        chk("sel1", 64'h0003_0101, got);
        acc(1, APEC_CTR_BASE + 1, 64'h8000_0000);
        acc(0, APEC_CTR_BASE + 1, 64'h0);
        chk("ctr1", 64'h00ff_8000_0000, got);
        acc(0, 32'h0000_0188, 64'h0);
        chk("unmapped", 64'h0, got);
        chk("eax", 64'h0028_0201, {32'h0, eax});
        chk("ebx", 64'hffff_fffa, {32'h0, ebx});
    endtask : t_regs
    task automatic cnt(input logic [63:0] s, input logic [1:0] p,
                       input logic [15:0] q, input logic [63:0] e);
        acc(1, APEC_SEL_BASE, 64'h0);
        acc(1, APEC_CTR_BASE, 64'h0);
        acc(1, APEC_SEL_BASE, s);
        cpl_i = p;
        for (int i = 0; i < 4; i++) begin
            occ_i[8 +: 4] = q[i*4 +: 4];
            @(negedge clk_i);
        end
        occ_i = '0;
        acc(1, APEC_SEL_BASE, 64'h0);
        acc(0, APEC_CTR_BASE, 64'h0);
        chk("count", e, got);
    endtask : cnt
    task automatic t_count();
        cnt(64'h0041_0102, 2'h3, 16'h1023, 64'h6);
        cnt(64'h0041_0102, 2'h0, 16'h1023, 64'h0);
        cnt(64'h0242_0102, 2'h0, 16'h1113, 64'h1);
        cnt(64'h02c2_0102, 2'h0, 16'h1113, 64'h5);
        cnt(64'h0045_0102, 2'h3, 16'h1011, 64'h2);
        cnt(64'h0001_0102, 2'h3, 16'h3333, 64'h0);
        cnt(64'h0041_0002, 2'h3, 16'h1111, 64'h0);
    endtask : t_count
    task automatic t_ovf();
        acc(1, APEC_CTR_BASE, 64'hffff_ffff);
        acc(0, APEC_CTR_BASE, 64'h0);
        chk("ctr0", 64'h00ff_ffff_ffff, got);
        acc(1, APEC_SEL_BASE, 64'h0051_0102);
        occ_i[8 +: 4] = 4'h1;
        si = 1'b0;
        sp = 1'b0;
        repeat (5) begin
            @(negedge clk_i);
            occ_i = '0;
            si = si | irq[0];
            sp = sp | pin[0];
        end
        chk("irq", 64'h1, {63'h0, si});
        chk("pin", 64'h1, {63'h0, sp});
        acc(1, APEC_SEL_BASE, 64'h0);
        acc(0, APEC_CTR_BASE, 64'h0);
        chk("wrap", 64'h0, got);
    endtask : t_ovf
    task automatic end_of_test();
        $display("checks %0d mismatches %0d", check_count, fail_count);
        if (fail_count == 0 && check_count > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask : end_of_test
    initial begin
        repeat (16) @(negedge clk_i);
        rst_i = 1'b0;
        t_regs();
        t_count();
        cpl_i = 2'h3;
        t_ovf();
        end_of_test();
    end
endmodule : tb_top
